/* File: core/simd_exc_params.svh */
// Register offsets, bit positions and reset values for the SIMD mode and exception block
`ifndef SIMD_EXC_PARAMS_SVH
`define SIMD_EXC_PARAMS_SVH

// Register byte offsets
`define MCW_OFFS        8'h00
`define ISR_MASK_OFFS   8'h04
`define STKY_PRI_OFFS   8'h08
`define STKY_SEC_OFFS   8'h0c
`define EXC_EN_OFFS     8'h10
`define CORE_STAT_OFFS  8'h14

// Mode control word bit positions
`define SECOND_EN_BIT   21
`define SSE_BIT         13
`define ROUND_TOWARD_ZERO_SELECT_BIT       5
`define ALU_SATURATE_ENABLE_BIT      3
`define SHORT_FLOAT_ROUNDING_BIT       16
`define RESULT_REGISTER_SWAP_BIT        2

// Mode bits that may be cleared on service routine entry
`define ISR_MASKABLE    32'h0001_202c

// Reset values
`define MCW_RST         32'h0000_0000
`define ISR_MASK_RST    32'h0000_0000
`define EXC_EN_RST      8'h00

// Sticky layout: bit t is ALU condition t, bit t+4 is multiplier condition t
`define UNIT_STRIDE     4

`endif

/* File: core/simd_exc_pkg.sv */
// Types shared by the SIMD mode and exception block
package simd_exc_pkg;

  // Operation broadcast to the processing elements
  typedef enum logic [1:0] {
    op_alu_add,
    op_mul,
    op_shift,
    op_idle
  } op_t;

endpackage : simd_exc_pkg

/* File: core/lane_if.sv */
// Connection between the control core and one processing element
interface lane_if #(
  parameter int DATA_W = 32,
  parameter int IDX_W  = 2
);
  logic                issue;
  simd_exc_pkg::op_t   op;
  logic [DATA_W-1:0]   x_opnd;
  logic                y_sel_imm;
  logic [DATA_W-1:0]   imm;
  logic [IDX_W-1:0]    src_idx;
  logic [IDX_W-1:0]    dest_idx;
  logic                bank;
  logic                swap;
  logic                saturate;
  logic [DATA_W-1:0]   result;
  logic                result_valid;
  logic                alu_ovf;
  logic                mul_ovf;

  modport ctrl (output issue, op, x_opnd, y_sel_imm, imm, src_idx, dest_idx, bank, swap,
                saturate, input result, result_valid, alu_ovf, mul_ovf);
  modport lane (input issue, op, x_opnd, y_sel_imm, imm, src_idx, dest_idx, bank, swap,
                saturate, output result, result_valid, alu_ovf, mul_ovf);
endinterface : lane_if

/* File: core/element_lane.sv */
// One processing element: ALU, multiplier with two result registers, shifter, banked registers
module element_lane #(
  parameter int DATA_W = 32,
  parameter int REGS   = 4
) (
  // Clock and reset
  input  wire logic ref_clk_in,
  input  wire logic rst_in,
  // Control side
  lane_if.lane      lif
);
  localparam int SH_W = $clog2(DATA_W);

  logic [DATA_W-1:0]   rf_q [2][REGS];
  logic [DATA_W-1:0]   mr_fg_q;
  logic [DATA_W-1:0]   mr_bg_q;
  logic [DATA_W-1:0]   res_q;
  logic                vld_q;
  logic                alu_ovf_q;
  logic                mul_ovf_q;
  logic                mul_q;
  logic                swap_q;
  logic [DATA_W-1:0]   res_d;

  // Immediate feeds both elements alike; otherwise the element's own register
  wire [DATA_W-1:0]   y_opnd = lif.y_sel_imm ? lif.imm : rf_q[lif.bank][lif.src_idx];

  wire [DATA_W:0]     sum = {lif.x_opnd[DATA_W-1], lif.x_opnd} + {y_opnd[DATA_W-1], y_opnd};
  wire                add_ovf = sum[DATA_W] ^ sum[DATA_W-1];
  wire [DATA_W-1:0]   sat_val = sum[DATA_W] ? {1'b1, {(DATA_W-1){1'b0}}}
                                            : {1'b0, {(DATA_W-1){1'b1}}};
  wire [DATA_W-1:0]   alu_res = (add_ovf && lif.saturate) ? sat_val : sum[DATA_W-1:0];
  wire [2*DATA_W-1:0] prod = $signed(lif.x_opnd) * $signed(y_opnd);
  wire [DATA_W:0]     prod_hi = prod[2*DATA_W-1:DATA_W-1];
  wire                prod_ovf = !((&prod_hi) || !(|prod_hi));
  wire [DATA_W-1:0]   shift_res = lif.x_opnd << y_opnd[SH_W-1:0];

  always_comb begin
    unique case (lif.op)
      simd_exc_pkg::op_alu_add: res_d = alu_res;
      simd_exc_pkg::op_mul:     res_d = prod[DATA_W-1:0];
      simd_exc_pkg::op_shift:   res_d = shift_res;
      simd_exc_pkg::op_idle:    res_d = lif.x_opnd;
    endcase
  end

  wire is_add = lif.issue && (lif.op == simd_exc_pkg::op_alu_add);
  wire is_mul = lif.issue && (lif.op == simd_exc_pkg::op_mul);

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      vld_q     <= 1'b0;
      alu_ovf_q <= 1'b0;
      mul_ovf_q <= 1'b0;
      mul_q     <= 1'b0;
      swap_q    <= 1'b0;
      res_q     <= '0;
      mr_fg_q   <= '0;
      mr_bg_q   <= '0;
      for (int b = 0; b < 2; b++) begin
        for (int i = 0; i < REGS; i++) begin
          rf_q[b][i] <= '0;
        end
      end
    end else begin
      vld_q     <= lif.issue;
      alu_ovf_q <= is_add && add_ovf;
      // Shifter results never raise an exception
      mul_ovf_q <= is_mul && prod_ovf; // [RL8]
      mul_q     <= is_mul;
      swap_q    <= lif.swap;
      if (lif.issue) begin
        res_q                          <= res_d;
        rf_q[lif.bank][lif.dest_idx] <= res_d;
      end
      if (is_mul && lif.swap) begin
        mr_bg_q <= prod[DATA_W-1:0]; // [RL6]
      end else if (is_mul) begin
        mr_fg_q <= prod[DATA_W-1:0]; // [RL6]
      end
    end
  end

  // The result register that the multiply wrote, chosen when it issued
  assign lif.result       = mul_q ? (swap_q ? mr_bg_q : mr_fg_q) : res_q;
  assign lif.result_valid = vld_q;
  assign lif.alu_ovf      = alu_ovf_q;
  assign lif.mul_ovf      = mul_ovf_q;

endmodule : element_lane

/* File: core/simd_mode_exception_control.sv */
// SIMD mode control, instruction broadcast, service-routine mode masking, arithmetic exceptions
//
// Overview of operation
// [RL1] Mode word bit 21 enables second element
// [RL2] Bit clear: one element; set: SIMD both
// [RL3] Mode change takes effect one cycle later
// [RL4] Shift immediate drives Y for both elements
// [RL5] One instruction, two data sets, two results
// [RL6] Each element: ALU, multiplier, shifter, registers
// [RL7] Service entry masks selected mode bits
// [RL8] Shifter never raises exception interrupts
// [RL9] Sticky one cycle, interrupt two cycles later
// [RL10] Enabled exception on either element interrupts once
// [RL11] Return keeps sticky bits until software clears
// [RL12] ALU four conditions, four shared vectors
// [RL13] Multiplier same four conditions, same vectors
// [RL14] Handler tests, clears sticky, then returns
// [RL15] Per-element sticky flags, held until cleared
`include "simd_exc_params.svh"

module simd_mode_exception_control #(
  parameter int DATA_W = 32,
  parameter int ADDR_W = 8,
  parameter int REGS   = 4
) (
  // Clock and reset
  input  wire logic                     ref_clk_in,
  input  wire logic                     rst_in,
  // APB slave
  input  wire logic                     psel_in,
  input  wire logic                     penable_in,
  input  wire logic                     pwrite_in,
  input  wire logic [ADDR_W-1:0]        paddr_in,
  input  wire logic [31:0]              pwdata_in,
  output logic [31:0]                   prdata_out,
  output logic                          pready_out,
  output logic                          pslverr_out,
  // Instruction issue
  input  wire logic                     issue_valid_in,
  input  wire simd_exc_pkg::op_t        issue_op_in,
  input  wire logic                     shift_imm_in,
  input  wire logic [DATA_W-1:0]        imm_in,
  input  wire logic [$clog2(REGS)-1:0]  src_idx_in,
  input  wire logic [$clog2(REGS)-1:0]  dest_idx_in,
  input  wire logic                     alt_bank_in,
  input  wire logic [1:0][DATA_W-1:0]   load_data_in,
  // Floating-point conditions per element: [2:0] ALU, [5:3] multiplier
  input  wire logic [1:0][5:0]          float_exc_in,
  // Service routine entry and return
  input  wire logic                     isr_entry_in,
  input  wire logic                     isr_return_in,
  // Results for storing
  output logic [1:0]                    store_valid_out,
  output logic [1:0][DATA_W-1:0]        store_data_out,
  // Mode state
  output logic                          simd_active_out,
  output logic                          short_word_sign_extend_out,
  output logic                          round_toward_zero_select_out,
  output logic                          alu_saturate_enable_out,
  output logic                          short_float_rounding_out,
  output logic                          result_register_swap_out,
  // Exception interrupts
  output logic [3:0]                    vector_pending_out,
  output logic                          exc_irq_out
);
  localparam int NT = `UNIT_STRIDE;
  localparam int SW = 2 * NT;

  ////////////////////////////////////////////////////////////////////////////////
  // APB decode

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [7:0] offs);
    reg_hit = (a == ADDR_W'(offs));
  endfunction : reg_hit

  // Only the access cycle acts; the setup cycle just latches read data
  wire setup_ph = psel_in && !penable_in;
  wire access   = psel_in && penable_in;
  wire wr_en    = access && pwrite_in;

  wire hit_mcw  = reg_hit(paddr_in, `MCW_OFFS);
  wire hit_imsk = reg_hit(paddr_in, `ISR_MASK_OFFS);
  wire hit_stp  = reg_hit(paddr_in, `STKY_PRI_OFFS);
  wire hit_sts  = reg_hit(paddr_in, `STKY_SEC_OFFS);
  wire hit_en   = reg_hit(paddr_in, `EXC_EN_OFFS);
  wire hit_stat = reg_hit(paddr_in, `CORE_STAT_OFFS);
  wire mapped   = hit_mcw || hit_imsk || hit_stp || hit_sts || hit_en || hit_stat;

  // Write strobes; an unmapped address matches none, so its writes drop
  wire wr_mcw   = wr_en && hit_mcw;
  wire wr_imsk  = wr_en && hit_imsk;
  wire wr_exen  = wr_en && hit_en;
  wire wr_stp   = wr_en && hit_stp;
  wire wr_sts   = wr_en && hit_sts;

  ////////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [31:0]         mode_q;
  logic [31:0]         mode_save_q;
  logic [31:0]         isr_mask_q;
  logic                in_isr_q;
  logic                simd_q;
  logic [SW-1:0]       exc_en_q;
  logic [1:0][SW-1:0]  sticky_q;
  logic [1:0][SW-1:0]  sticky_d;
  logic [3:0]          vec_q;
  logic [3:0]          vec_d;
  logic [31:0]         prdata_q;
  logic [31:0]         mode_d;
  logic [31:0]         rd_mux;

  // Selected mode bits drop on service entry and come back on return
  wire [31:0] entry_mode = mode_q & ~(isr_mask_q & `ISR_MASKABLE); // [RL7]

  // Entry outranks return, which outranks a bus write
  always_comb begin
    mode_d = mode_q;
    if (isr_entry_in) begin
      mode_d = entry_mode; // [RL7]
    end else if (isr_return_in && in_isr_q) begin
      mode_d = mode_save_q;
    end else if (wr_mcw) begin
      mode_d = pwdata_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      mode_q      <= `MCW_RST;
      mode_save_q <= `MCW_RST;
      in_isr_q    <= 1'b0;
    end else begin
      mode_q <= mode_d;
      // The word in force before entry is kept for the return
      if (isr_entry_in) begin
        mode_save_q <= mode_q;
        in_isr_q    <= 1'b1;
      end else if (isr_return_in) begin
        in_isr_q <= 1'b0;
      end
    end
  end

  // The element count follows the mode word one cycle late,
  // so an issue right after a mode write still sees the old count
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      simd_q <= 1'b0;
    end else begin
      simd_q <= mode_q[`SECOND_EN_BIT]; // [RL1] [RL3]
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      isr_mask_q <= `ISR_MASK_RST;
      exc_en_q   <= `EXC_EN_RST;
    end else begin
      // Bits outside the maskable set never reach the mask
      if (wr_imsk) begin
        isr_mask_q <= pwdata_in & `ISR_MASKABLE;
      end
      if (wr_exen) begin
        exc_en_q <= pwdata_in[SW-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Processing elements

  lane_if #(.DATA_W(DATA_W), .IDX_W($clog2(REGS))) lanes [2] ();

  logic [1:0][SW-1:0] exc_evt;

  generate
    for (genvar e = 0; e < 2; e++) begin : g_pe
      // Element 1 takes part only in SIMD mode
      wire pe_on = (e == 0) || simd_q; // [RL2]

      assign lanes[e].issue     = issue_valid_in && pe_on; // [RL5]
      assign lanes[e].op        = issue_op_in; // [RL5]
      assign lanes[e].x_opnd    = load_data_in[e]; // [RL5]
      assign lanes[e].y_sel_imm = shift_imm_in && (issue_op_in == simd_exc_pkg::op_shift); // [RL4]
      assign lanes[e].imm       = imm_in; // [RL4]
      assign lanes[e].src_idx   = src_idx_in;
      assign lanes[e].dest_idx  = dest_idx_in;
      assign lanes[e].bank      = alt_bank_in;
      // Swap and saturation follow the live word, so entry masking acts at once
      assign lanes[e].swap      = mode_q[`RESULT_REGISTER_SWAP_BIT];
      assign lanes[e].saturate  = mode_q[`ALU_SATURATE_ENABLE_BIT];

      element_lane #(
        .DATA_W (DATA_W),
        .REGS   (REGS)
      ) u_lane (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .lif        (lanes[e])
      ); // [RL6]

      // Element 1 conditions are ignored while it is switched off
      // Only ALU and multiplier conditions reach the sticky bits
      assign exc_evt[e] = {float_exc_in[e][5:3] & {3{pe_on}}, lanes[e].mul_ovf,
                           float_exc_in[e][2:0] & {3{pe_on}}, lanes[e].alu_ovf}; // [RL8]

      wire clr_hit = (e == 0) ? wr_stp : wr_sts;
      wire [SW-1:0] clr_bits = clr_hit ? pwdata_in[SW-1:0] : '0;

      // A new event wins over a clear in the same cycle
      assign sticky_d[e] = exc_evt[e] | (sticky_q[e] & ~clr_bits); // [RL15] [RL11] [RL14]

      // Results leave through a register, so valid and data line up
      always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
          store_data_out[e] <= '0;
          store_valid_out[e] <= 1'b0;
        end else begin
          store_valid_out[e] <= lanes[e].result_valid; // [RL5]
          store_data_out[e]  <= lanes[e].result;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Sticky status and interrupt vectors

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      sticky_q <= '0;
    end else begin
      sticky_q <= sticky_d; // [RL9] [RL15]
    end
  end

  // ALU and multiplier share one vector per condition, both elements merged
  generate
    for (genvar t = 0; t < NT; t++) begin : g_vec
      wire [1:0] alu_t = {sticky_q[1][t], sticky_q[0][t]} & {2{exc_en_q[t]}};
      wire [1:0] mul_t = {sticky_q[1][t+NT], sticky_q[0][t+NT]} & {2{exc_en_q[t+NT]}};
      wire       alu_any = |alu_t; // [RL12]
      wire       mul_any = |mul_t; // [RL13]
      // Either element, or both, gives one pending condition
      assign vec_d[t] = alu_any || mul_any; // [RL10]
    end
  endgenerate

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      vec_q <= '0;
    end else begin
      vec_q <= vec_d; // [RL9]
    end
  end

  assign vector_pending_out = vec_q;
  assign exc_irq_out        = |vec_q; // [RL10]

  ////////////////////////////////////////////////////////////////////////////////
  // Read data and bus answer

  // Sticky and enable words fill the low byte; the rest reads as zero
  function automatic logic [31:0] low_byte(input logic [SW-1:0] v);
    low_byte = {{(32-SW){1'b0}}, v};
  endfunction : low_byte

  // Status word packs vectors, in-service flag and element count
  assign rd_mux = hit_mcw  ? mode_q :
                  hit_imsk ? isr_mask_q :
                  hit_stp  ? low_byte(sticky_q[0]) :
                  hit_sts  ? low_byte(sticky_q[1]) :
                  hit_en   ? low_byte(exc_en_q) :
                  hit_stat ? {26'h0, vec_q, in_isr_q, simd_q} :
                  32'h0000_0000;

  // Read data is taken in the setup cycle and holds through the access
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      prdata_q <= '0;
    end else if (setup_ph) begin
      prdata_q <= rd_mux;
    end
  end

  assign prdata_out  = prdata_q;
  // No wait states: every access completes in its first access cycle
  assign pready_out  = access;
  assign pslverr_out = access && !mapped;

  ////////////////////////////////////////////////////////////////////////////////
  // Mode outputs

  assign simd_active_out              = simd_q; // [RL2]
  assign short_word_sign_extend_out   = mode_q[`SSE_BIT];
  assign round_toward_zero_select_out = mode_q[`ROUND_TOWARD_ZERO_SELECT_BIT];
  assign alu_saturate_enable_out      = mode_q[`ALU_SATURATE_ENABLE_BIT];
  assign short_float_rounding_out     = mode_q[`SHORT_FLOAT_ROUNDING_BIT];
  assign result_register_swap_out     = mode_q[`RESULT_REGISTER_SWAP_BIT];

endmodule : simd_mode_exception_control

/* File: test/simd_exc_monitor.sv */
// Port-level concurrent checks for the SIMD mode and exception block
`include "simd_exc_params.svh"

module simd_exc_monitor #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic              ref_clk_in,
  input wire logic              rst_in,
  // APB
  input wire logic              psel_in,
  input wire logic              penable_in,
  input wire logic              pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0]       pwdata_in,
  input wire logic              pslverr_out,
  // Issue and events
  input wire logic              issue_valid_in,
  input wire simd_exc_pkg::op_t issue_op_in,
  input wire logic [1:0][5:0]   float_exc_in,
  input wire logic              isr_entry_in,
  input wire logic              isr_return_in,
  // Observed state
  input wire logic [1:0]        store_valid_out,
  input wire logic              simd_active_out,
  input wire logic              short_word_sign_extend_out,
  input wire logic [3:0]        vector_pending_out,
  input wire logic              exc_irq_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);

  // Shadows of the enable register and of the SSE bit of the entry mask
  logic [7:0] en_q;
  logic       mask_sse_q;
  wire        acc    = psel_in && penable_in;
  wire        mapped = paddr_in inside {`MCW_OFFS, `ISR_MASK_OFFS, `STKY_PRI_OFFS,
                                        `STKY_SEC_OFFS, `EXC_EN_OFFS, `CORE_STAT_OFFS};
  wire        wr_ok  = acc && pwrite_in && mapped;
  wire        mode_wr = wr_ok && paddr_in == `MCW_OFFS && !isr_entry_in && !isr_return_in;
  wire        clr_wr = wr_ok && paddr_in inside {`STKY_PRI_OFFS, `STKY_SEC_OFFS, `EXC_EN_OFFS};
  wire [5:0]  en6    = {en_q[7:5], en_q[3:1]};
  wire        exc_ev = (|(float_exc_in[0] & en6)) ||
                       (simd_active_out && (|(float_exc_in[1] & en6)));

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      en_q       <= 8'h00;
      mask_sse_q <= 1'b0;
    end else if (wr_ok && paddr_in == `EXC_EN_OFFS) begin
      en_q <= pwdata_in[7:0];
    end else if (wr_ok && paddr_in == `ISR_MASK_OFFS) begin
      mask_sse_q <= pwdata_in[`SSE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_unmapped_err: assert property (acc && !mapped |-> pslverr_out)
    else $error("unmapped access without error response");
  a_mode_delay: assert property (
    mode_wr |=> $stable(simd_active_out) ##1 simd_active_out == $past(pwdata_in[21], 2))
    else $error("mode change not exactly one cycle late");
  a_single_lane: assert property (
    issue_valid_in && !simd_active_out |-> ##2 !store_valid_out[1])
    else $error("second element stored in single mode");
  a_issue_store: assert property (
    issue_valid_in && issue_op_in != simd_exc_pkg::op_idle |-> ##2 store_valid_out[0])
    else $error("issue produced no store");
  a_exc_irq: assert property (
    exc_ev |-> ##2 (exc_irq_out && vector_pending_out != 4'h0))
    else $error("enabled exception gave no interrupt in two cycles");
  a_sticky_held: assert property (
    $fell(exc_irq_out) |-> ($past(clr_wr, 1) || $past(clr_wr, 2)))
    else $error("interrupt dropped without a clearing write");
  a_entry_mask: assert property (
    isr_entry_in && mask_sse_q |-> ##[1:2] !short_word_sign_extend_out)
    else $error("masked mode bit survived service entry");
  a_shift_quiet: assert property (
    (issue_valid_in && issue_op_in == simd_exc_pkg::op_shift && float_exc_in == '0 &&
     vector_pending_out == 4'h0) ##1 (float_exc_in == '0 && !issue_valid_in)
    |-> ##2 vector_pending_out == 4'h0)
    else $error("shift raised an exception vector");

  c_mode_wr: cover property (mode_wr);
  c_exc_ev: cover property (exc_ev);
  c_entry: cover property (isr_entry_in && mask_sse_q);
endmodule : simd_exc_monitor

/* File: test/simd_mode_exception_control_bench.sv */
// Self-checking bench for the SIMD mode and exception block
`include "simd_exc_params.svh"

module simd_mode_exception_control_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic              ref_clk_in     = 1'b0;
  logic              rst_in         = 1'b1;
  logic              psel_in        = 1'b0;
  logic              penable_in     = 1'b0;
  logic              pwrite_in      = 1'b0;
  logic [7:0]        paddr_in       = 8'h00;
  logic [31:0]       pwdata_in      = 32'h0;
  logic              issue_valid_in = 1'b0;
  simd_exc_pkg::op_t issue_op_in    = simd_exc_pkg::op_alu_add;
  logic [1:0][31:0]  load_data_in   = {32'h1, 32'h2};
  logic [1:0][5:0]   float_exc_in   = '0;
  logic              isr_entry_in   = 1'b0;
  logic              isr_return_in  = 1'b0;
  logic [31:0]       prdata_out;
  logic              pready_out;
  logic              pslverr_out;
  logic [1:0]        store_valid_out;
  logic [1:0][31:0]  store_data_out;
  logic [5:0]        mode_bits;
  logic [3:0]        vector_pending_out;
  logic              exc_irq_out;
  int                n_errors       = 0;
  int                compares       = 0;
  int                cycles         = 0;
  wire  [31:0]       modes          = {26'h0, mode_bits};
  wire  [31:0]       irqs           = {27'h0, exc_irq_out, vector_pending_out};

  simd_mode_exception_control dut (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .issue_valid_in(issue_valid_in), .issue_op_in(issue_op_in), .shift_imm_in(1'b1),
    .imm_in(32'h4), .src_idx_in(2'h1), .dest_idx_in(2'h1), .alt_bank_in(1'b0),
    .load_data_in(load_data_in), .float_exc_in(float_exc_in),
    .isr_entry_in(isr_entry_in), .isr_return_in(isr_return_in),
    .store_valid_out(store_valid_out), .store_data_out(store_data_out),
    .simd_active_out(mode_bits[5]), .short_word_sign_extend_out(mode_bits[4]),
    .round_toward_zero_select_out(mode_bits[3]), .alu_saturate_enable_out(mode_bits[2]),
    .short_float_rounding_out(mode_bits[1]), .result_register_swap_out(mode_bits[0]),
    .vector_pending_out(vector_pending_out), .exc_irq_out(exc_irq_out));

  always #20 ref_clk_in = ~ref_clk_in;

  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      conclude();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    if (n_errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge ref_clk_in);
    psel_in   <= 1'b1;
    pwrite_in <= w;
    paddr_in  <= a;
    pwdata_in <= d;
    @(posedge ref_clk_in);
    penable_in <= 1'b1;
    @(posedge ref_clk_in);
    while (pready_out !== 1'b1) @(posedge ref_clk_in);
    r = prdata_out;
    e = pslverr_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    check(r, exp);
  endtask : rd

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask : wait_cyc

  task automatic issue(input simd_exc_pkg::op_t op, input int pre, input logic [1:0] exp);
    repeat (pre) @(posedge ref_clk_in);
    issue_valid_in <= 1'b1;
    issue_op_in    <= op;
    @(posedge ref_clk_in);
    issue_valid_in <= 1'b0;
    wait_cyc(1);
    check({30'h0, store_valid_out}, {30'h0, exp});
  endtask : issue

  task automatic strobe(input logic ret);
    @(posedge ref_clk_in);
    if (ret) isr_return_in <= 1'b1;
    else isr_entry_in <= 1'b1;
    @(posedge ref_clk_in);
    isr_return_in <= 1'b0;
    isr_entry_in  <= 1'b0;
  endtask : strobe

  // Exception pulse on one element, then pending vector and interrupt two cycles on
  task automatic pulse(input int el, input int k, input logic [4:0] exp);
    @(posedge ref_clk_in);
    float_exc_in[el][k] <= 1'b1;
    @(posedge ref_clk_in);
    float_exc_in <= '0;
    wait_cyc(2);
    check(irqs, {27'h0, exp});
  endtask : pulse

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] r;
    logic        e;
    int          sb;
    repeat (20) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    rd(`MCW_OFFS, `MCW_RST);
    apb(1'b0, 8'h18, 32'h0, r, e);
    check({31'h0, e}, 32'h1);
    issue(simd_exc_pkg::op_alu_add, 1, 2'b01);
    fork
      wr(`MCW_OFFS, 32'h0020_0000);
      issue(simd_exc_pkg::op_mul, 3, 2'b01);
    join
    issue(simd_exc_pkg::op_alu_add, 1, 2'b11);
    @(posedge ref_clk_in);
    load_data_in <= {32'h9, 32'h3};
    issue(simd_exc_pkg::op_shift, 1, 2'b11);
    check(store_data_out[0], 32'h3 << 4);
    check(store_data_out[1], 32'h9 << 4);
    wr(`EXC_EN_OFFS, 32'h0000_00ff);
    for (int el = 0; el < 2; el++) begin
      for (int k = 0; k < 6; k++) begin
        sb = (k < 3) ? k + 1 : k + 2;
        pulse(el, k, 5'h10 | (5'h1 << (k % 3 + 1)));
        rd(`STKY_PRI_OFFS + 8'(4 * el), 32'h1 << sb);
        rd(`STKY_SEC_OFFS - 8'(4 * el), 32'h0);
        strobe(1'b1);
        rd(`STKY_PRI_OFFS + 8'(4 * el), 32'h1 << sb);
        wr(`STKY_PRI_OFFS + 8'(4 * el), 32'h1 << sb);
        wait_cyc(2);
        check(irqs, 32'h0);
      end
    end
    wr(`MCW_OFFS, 32'h0);
    pulse(1, 0, 5'h00);
    rd(`STKY_SEC_OFFS, 32'h0);
    wr(`EXC_EN_OFFS, 32'h0000_00fd);
    pulse(0, 0, 5'h00);
    rd(`STKY_PRI_OFFS, 32'h2);
    wr(`STKY_PRI_OFFS, 32'h2);
    wr(`EXC_EN_OFFS, 32'h0000_00ff);
    issue(simd_exc_pkg::op_shift, 1, 2'b01);
    wait_cyc(2);
    check(irqs, 32'h0);
    @(posedge ref_clk_in);
    load_data_in <= {32'h0, 32'h7fff_ffff};
    issue(simd_exc_pkg::op_alu_add, 1, 2'b01);
    wait_cyc(1);
    check(irqs, 32'h11);
    check(store_data_out[0], 32'h7fff_ffff + (32'h3 << 4));
    wr(`STKY_PRI_OFFS, 32'h1);
    wr(`ISR_MASK_OFFS, `ISR_MASKABLE);
    wr(`MCW_OFFS, `ISR_MASKABLE | 32'h0020_0000);
    wait_cyc(2);
    check(modes, 32'h3f);
    strobe(1'b0);
    wait_cyc(2);
    check(modes, 32'h20);
    strobe(1'b1);
    wait_cyc(2);
    check(modes, 32'h3f);
    conclude();
  end
endmodule : simd_mode_exception_control_bench

bind simd_mode_exception_control simd_exc_monitor #(.ADDR_W(ADDR_W)) u_mon (
  .ref_clk_in(ref_clk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
  .pslverr_out(pslverr_out), .issue_valid_in(issue_valid_in), .issue_op_in(issue_op_in),
  .float_exc_in(float_exc_in), .isr_entry_in(isr_entry_in), .isr_return_in(isr_return_in),
  .store_valid_out(store_valid_out), .simd_active_out(simd_active_out),
  .short_word_sign_extend_out(short_word_sign_extend_out),
  .vector_pending_out(vector_pending_out), .exc_irq_out(exc_irq_out));
